// ==== logic/rta_pkg.sv ====
// constants, types and helpers shared by the alarm, pulse, interrupt and trim logic
// assumes one 40 MHz clock and a one-cycle oscillator strobe per 32.768 kHz period
package rta_pkg;
    localparam logic [7:0] ADDR_STAT0 = 8'h00;
    localparam logic [7:0] ADDR_STAT1 = 8'h01;
    localparam logic [7:0] ADDR_STAT2 = 8'h02;
    localparam logic [7:0] ADDR_TRIM = 8'h10;
    localparam logic [7:0] ADDR_CLK_BASE = 8'h20;
    localparam logic [7:0] ADDR_ALM_BASE = 8'h30;
    localparam logic [7:0] ADDR_TIM_BASE = 8'h40;
    localparam logic [7:0] ADDR_CMD_BOTH = 8'hF0;
    localparam logic [7:0] ADDR_CMD_CLK = 8'hF1;
    localparam logic [7:0] ADDR_CMD_TIM = 8'hF2;
    localparam logic [7:0] CLK_RAM_LEN = 8'h09;
    localparam logic [7:0] ALM_LEN = 8'h05;
    localparam logic [7:0] TIM_LEN = 8'h04;
    localparam int RCLK_FIELDS = 5;
    localparam int RTIM_FIELDS = 4;
    localparam int COUNT_FIELDS = 4;
    // status 0 bits
    localparam int S0_PULSE_EN = 1;
    localparam int S0_ALARM_EN = 2;
    localparam int S0_TIMER_EN = 3;
    localparam int S0_LOCK = 5;
    // status 1 bits
    localparam int S1_PULSE_MASK = 0;
    localparam int S1_ALARM_MASK = 1;
    localparam int S1_TIMER_MASK = 2;
    localparam int S1_PULSE_FLAG = 4;
    localparam int S1_ALARM_FLAG = 5;
    localparam int S1_TIMER_FLAG = 6;
    // status 2 bits
    localparam int S2_SEL_10MS = 0;
    localparam int S2_SEL_100MS = 1;
    localparam int S2_SEL_1S = 2;
    localparam int S2_SEL_1MIN = 3;
    localparam int S2_INIT = 4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] ALARM_DONT_CARE = 8'hFF;
    localparam logic [7:0] READ_FILL = 8'h00;
    // bcd limits of hundredths, seconds, minutes, hours
    localparam logic [7:0] MAX_HSEC = 8'h99;
    localparam logic [7:0] MAX_SEC = 8'h59;
    localparam logic [7:0] MAX_MIN = 8'h59;
    localparam logic [7:0] MAX_HOUR = 8'h23;
    // divider and trim timing
    localparam int OSC_HZ = 32768;
    localparam int TICK_MS = 10;
    localparam int TICK_HZ = 1000 / TICK_MS;
    localparam int TRIM_PERIOD_S = 31;
    localparam int TRIM_PERIOD_CYC = TRIM_PERIOD_S * OSC_HZ;
    localparam logic [15:0] ACC_STEP = 16'(TICK_HZ);
    localparam logic [15:0] ACC_WRAP = 16'(OSC_HZ);
    // pulse interval dividers in parent ticks
    localparam logic [5:0] DIV_100MS = 6'h0A;
    localparam logic [5:0] DIV_1S = 6'h0A;
    localparam logic [5:0] DIV_1MIN = 6'h3C;

    typedef enum logic [1:0] {
        RTA_BUS_IDLE = 2'b00,
        RTA_BUS_WRITE = 2'b01,
        RTA_BUS_READ = 2'b10
    } rta_bus_state_t;

    // bcd increment; out of range values clear with carry
    function automatic logic [8:0] rta_bcd_inc(input logic [7:0] v, input logic [7:0] vmax);
        logic [8:0] r;
        r = 9'h000;
        if (v >= vmax) begin
            r = 9'h100;
        end else if (v[3:0] >= 4'h9) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    function automatic logic [7:0] rta_field_max(input int idx);
        logic [7:0] m;
        case (idx)
            0: m = MAX_HSEC;
            1: m = MAX_SEC;
            2: m = MAX_MIN;
            default: m = MAX_HOUR;
        endcase
        return m;
    endfunction

    function automatic logic rta_in_range(input logic [7:0] a, input logic [7:0] base, input logic [7:0] len);
        return (a >= base) && (a < 8'(base + len));
    endfunction

    function automatic logic rta_onehot4(input logic [3:0] v);
        return (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
    endfunction
endpackage

// ==== logic/rta_tick_if.sv ====
// interval strobes from the trimmed divider to the pulse and alarm logic
// assumes all strobes are one clk cycle wide in the clk domain
`timescale 1ns/1ps
`default_nettype none
interface rta_tick_if;
    logic tick_10ms;
    logic tick_100ms;
    logic tick_1s;
    logic tick_1min;
    modport div_mp (output tick_10ms);
    modport pul_mp (input tick_10ms, output tick_100ms, output tick_1s, output tick_1min);
    modport core_mp (input tick_10ms, input tick_100ms, input tick_1s, input tick_1min);
endinterface
`default_nettype wire

// ==== logic/rta_trim_div.sv ====
// trimmed divider: oscillator strobes to a 100 Hz update tick
// assumes osc_pulse is one clk cycle per oscillator period
`timescale 1ns/1ps
`default_nettype none
module rta_trim_div #(
    parameter int TRIM_PERIOD = rta_pkg::TRIM_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic osc_pulse,
    input wire logic [7:0] trim_value,
    rta_tick_if.div_mp ticks
);
    typedef struct packed {
        logic [19:0] period_cnt;
        logic [7:0] remove_cnt;
        logic [15:0] acc;
        logic tick;
    } rta_div_state_t;

    rta_div_state_t s_reg;
    rta_div_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (osc_pulse) begin
            // pending removals swallow pulses before the divider sees them
            if (s_reg.remove_cnt != 8'h00) begin
                s_next.remove_cnt = s_reg.remove_cnt - 8'h01;
            end else if (s_reg.acc + rta_pkg::ACC_STEP >= rta_pkg::ACC_WRAP) begin
                s_next.acc = s_reg.acc + rta_pkg::ACC_STEP - rta_pkg::ACC_WRAP;
                s_next.tick = 1'b1;
            end else begin
                s_next.acc = s_reg.acc + rta_pkg::ACC_STEP;
            end
            // period counts every oscillator cycle, swallowed or not
            if (s_reg.period_cnt == 20'(TRIM_PERIOD - 1)) begin
                s_next.period_cnt = 20'h00000;
                s_next.remove_cnt = trim_value;
            end else begin
                s_next.period_cnt = s_reg.period_cnt + 20'h00001;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ticks.tick_10ms = s_reg.tick;
endmodule // rta_trim_div
`default_nettype wire

// ==== logic/rta_pulse_gen.sv ====
// derives 100 ms, 1 s and 1 min strobes from the 10 ms tick
// assumes tick_10ms is a one-cycle strobe
`timescale 1ns/1ps
`default_nettype none
module rta_pulse_gen (
    input wire logic clk,
    input wire logic sys_rst,
    rta_tick_if.pul_mp ticks
);
    typedef struct packed {
        logic [5:0] c100;
        logic [5:0] c1s;
        logic [5:0] c1m;
        logic t100;
        logic t1s;
        logic t1m;
    } rta_pul_state_t;

    rta_pul_state_t s_reg;
    rta_pul_state_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.t100 = 1'b0;
        s_next.t1s = 1'b0;
        s_next.t1m = 1'b0;
        if (ticks.tick_10ms) begin
            if (s_reg.c100 == rta_pkg::DIV_100MS - 6'h01) begin
                s_next.c100 = 6'h00;
                s_next.t100 = 1'b1;
                if (s_reg.c1s == rta_pkg::DIV_1S - 6'h01) begin
                    s_next.c1s = 6'h00;
                    s_next.t1s = 1'b1;
                    if (s_reg.c1m == rta_pkg::DIV_1MIN - 6'h01) begin
                        s_next.c1m = 6'h00;
                        s_next.t1m = 1'b1;
                    end else begin
                        s_next.c1m = s_reg.c1m + 6'h01;
                    end
                end else begin
                    s_next.c1s = s_reg.c1s + 6'h01;
                end
            end else begin
                s_next.c100 = s_reg.c100 + 6'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ticks.tick_100ms = s_reg.t100;
    assign ticks.tick_1s = s_reg.t1s;
    assign ticks.tick_1min = s_reg.t1m;
endmodule // rta_pulse_gen
`default_nettype wire

// ==== logic/rta_core.sv ====
// clock core: multiplexed byte bus, alarm, timer, pulse, interrupt pin, lock and trim
// assumes bus pins and osc_pulse are synchronous to clk; irq pin has an external pullup
`timescale 1ns/1ps
`default_nettype none
module rta_core #(
    parameter int TRIM_PERIOD = rta_pkg::TRIM_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic osc_pulse,
    input wire logic power_fail_input,
    input wire logic bus_cs_n,
    input wire logic bus_rd_n,
    input wire logic bus_wr_n,
    input wire logic bus_data_sel,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe_n,
    output logic irq_out,
    output logic irq_oe_n
);
    typedef struct packed {
        rta_pkg::rta_bus_state_t bus;
        logic [7:0] addr_latch;
        logic [2:0][7:0] stat;
        logic [7:0] trim;
        logic [8:0][7:0] cram;
        logic [4:0][7:0] aram;
        logic [3:0][7:0] tram;
        logic [4:0][7:0] rclk;
        logic [3:0][7:0] rtim;
        logic [7:0] ad_out;
        logic ad_oe_n;
        logic irq_out;
        logic irq_oe_n;
    } rta_core_state_t;

    rta_core_state_t s_reg;
    rta_core_state_t s_next;
    rta_tick_if ticks ();

    rta_trim_div #(
        .TRIM_PERIOD(TRIM_PERIOD)
    ) u_div (
        .clk(clk),
        .sys_rst(sys_rst),
        .osc_pulse(osc_pulse),
        .trim_value(s_reg.trim),
        .ticks(ticks.div_mp)
    );

    rta_pulse_gen u_pul (
        .clk(clk),
        .sys_rst(sys_rst),
        .ticks(ticks.pul_mp)
    );

    // byte read mux over the register map
    function automatic logic [7:0] rd_byte(input rta_core_state_t st, input logic [7:0] a);
        logic [7:0] d;
        d = rta_pkg::READ_FILL;
        if (a == rta_pkg::ADDR_STAT0 || a == rta_pkg::ADDR_STAT1 || a == rta_pkg::ADDR_STAT2) begin
            d = st.stat[a[1:0]];
        end else if (a == rta_pkg::ADDR_TRIM) begin
            d = st.trim;
        end else if (rta_pkg::rta_in_range(a, rta_pkg::ADDR_CLK_BASE, rta_pkg::CLK_RAM_LEN)) begin
            d = st.cram[4'(a - rta_pkg::ADDR_CLK_BASE)];
        end else if (rta_pkg::rta_in_range(a, rta_pkg::ADDR_ALM_BASE, rta_pkg::ALM_LEN)) begin
            d = st.aram[3'(a - rta_pkg::ADDR_ALM_BASE)];
        end else if (rta_pkg::rta_in_range(a, rta_pkg::ADDR_TIM_BASE, rta_pkg::TIM_LEN)) begin
            d = st.tram[2'(a - rta_pkg::ADDR_TIM_BASE)];
        end
        return d;
    endfunction

    function automatic logic is_cmd(input logic [7:0] a);
        return a == rta_pkg::ADDR_CMD_BOTH || a == rta_pkg::ADDR_CMD_CLK || a == rta_pkg::ADDR_CMD_TIM;
    endfunction

    logic wr_start;
    logic rd_start;
    logic lock;
    logic alarm_match;
    logic alarm_ev;
    logic timer_ev;
    logic pulse_ev;
    logic pulse_hit;
    logic carry;
    logic [8:0] inc;
    logic [3:0] psel;
    logic [7:0] a;
    logic irq_alarm;
    logic irq_other;

    always_comb begin
        s_next = s_reg;
        a = s_reg.addr_latch;
        lock = s_reg.stat[0][rta_pkg::S0_LOCK];
        wr_start = !bus_cs_n && !bus_wr_n && bus_rd_n;
        rd_start = !bus_cs_n && !bus_rd_n && bus_wr_n;
        alarm_ev = 1'b0;
        timer_ev = 1'b0;
        carry = 1'b0;
        inc = 9'h000;

        // alarm compare against the running clock before this tick advances it
        alarm_match = 1'b1;
        for (int i = 0; i < rta_pkg::RCLK_FIELDS; i++) begin
            if (s_reg.aram[i] != rta_pkg::ALARM_DONT_CARE && s_reg.aram[i] != s_reg.rclk[i]) begin
                alarm_match = 1'b0;
            end
        end
        if (ticks.tick_10ms && s_reg.stat[0][rta_pkg::S0_ALARM_EN] && alarm_match) begin
            alarm_ev = 1'b1;
        end

        // running clock; date held, calendar is not counted here
        if (ticks.tick_10ms) begin
            carry = 1'b1;
            for (int i = 0; i < rta_pkg::COUNT_FIELDS; i++) begin
                if (carry) begin
                    inc = rta_pkg::rta_bcd_inc(s_reg.rclk[i], rta_pkg::rta_field_max(i));
                    s_next.rclk[i] = inc[7:0];
                    carry = inc[8];
                end
            end
        end

        // elapsed timer, counts in standby too
        if (ticks.tick_10ms && s_reg.stat[0][rta_pkg::S0_TIMER_EN]) begin
            carry = 1'b1;
            for (int i = 0; i < rta_pkg::RTIM_FIELDS; i++) begin
                if (carry) begin
                    inc = rta_pkg::rta_bcd_inc(s_reg.rtim[i], rta_pkg::rta_field_max(i));
                    s_next.rtim[i] = inc[7:0];
                    carry = inc[8];
                end
            end
            timer_ev = carry;
        end

        // pulse interval selection
        psel = s_reg.stat[2][3:0];
        pulse_hit = (psel[rta_pkg::S2_SEL_10MS] && ticks.tick_10ms)
                 || (psel[rta_pkg::S2_SEL_100MS] && ticks.tick_100ms)
                 || (psel[rta_pkg::S2_SEL_1S] && ticks.tick_1s)
                 || (psel[rta_pkg::S2_SEL_1MIN] && ticks.tick_1min);
        pulse_ev = pulse_hit && rta_pkg::rta_onehot4(psel)
                && s_reg.stat[0][rta_pkg::S0_PULSE_EN]
                && !power_fail_input;

        // bus access taken on the strobe's leading edge
        case (s_reg.bus)
            rta_pkg::RTA_BUS_IDLE: begin
                if (wr_start) begin
                    s_next.bus = rta_pkg::RTA_BUS_WRITE;
                    if (!bus_data_sel) begin
                        s_next.addr_latch = ad_in;
                    end else if (a == rta_pkg::ADDR_STAT0 || a == rta_pkg::ADDR_STAT1 || a == rta_pkg::ADDR_STAT2) begin
                        s_next.stat[a[1:0]] = ad_in;
                        if (a == rta_pkg::ADDR_STAT2 && ad_in[rta_pkg::S2_INIT]) begin
                            s_next.stat[0] = rta_pkg::REG_RESET;
                            s_next.stat[1] = rta_pkg::REG_RESET;
                        end
                    end else if (a == rta_pkg::ADDR_TRIM) begin
                        if (!lock) begin
                            s_next.trim = ad_in;
                        end
                    end else if (rta_pkg::rta_in_range(a, rta_pkg::ADDR_CLK_BASE, rta_pkg::CLK_RAM_LEN)) begin
                        s_next.cram[4'(a - rta_pkg::ADDR_CLK_BASE)] = ad_in;
                    end else if (rta_pkg::rta_in_range(a, rta_pkg::ADDR_ALM_BASE, rta_pkg::ALM_LEN)) begin
                        s_next.aram[3'(a - rta_pkg::ADDR_ALM_BASE)] = ad_in;
                    end else if (rta_pkg::rta_in_range(a, rta_pkg::ADDR_TIM_BASE, rta_pkg::TIM_LEN)) begin
                        s_next.tram[2'(a - rta_pkg::ADDR_TIM_BASE)] = ad_in;
                    end else if (is_cmd(a) && !lock) begin
                        if (a != rta_pkg::ADDR_CMD_TIM) begin
                            for (int i = 0; i < rta_pkg::RCLK_FIELDS; i++) begin
                                s_next.rclk[i] = s_reg.cram[i];
                            end
                        end
                        if (a != rta_pkg::ADDR_CMD_CLK) begin
                            s_next.rtim = s_reg.tram;
                        end
                    end
                end else if (rd_start) begin
                    s_next.bus = rta_pkg::RTA_BUS_READ;
                    if (!bus_data_sel) begin
                        s_next.ad_out = s_reg.addr_latch;
                    end else begin
                        s_next.ad_out = rd_byte(s_reg, a);
                        if (is_cmd(a)) begin
                            if (a != rta_pkg::ADDR_CMD_TIM) begin
                                for (int i = 0; i < rta_pkg::RCLK_FIELDS; i++) begin
                                    s_next.cram[i] = s_reg.rclk[i];
                                end
                            end
                            if (a != rta_pkg::ADDR_CMD_CLK) begin
                                s_next.tram = s_reg.rtim;
                            end
                        end
                    end
                end
            end
            rta_pkg::RTA_BUS_WRITE: begin
                if (bus_cs_n || bus_wr_n) begin
                    s_next.bus = rta_pkg::RTA_BUS_IDLE;
                end
            end
            rta_pkg::RTA_BUS_READ: begin
                if (bus_cs_n || bus_rd_n) begin
                    s_next.bus = rta_pkg::RTA_BUS_IDLE;
                end
            end
            default: begin
                s_next.bus = rta_pkg::RTA_BUS_IDLE;
            end
        endcase
        s_next.ad_oe_n = (s_next.bus != rta_pkg::RTA_BUS_READ);

        // hardware only sets flags; a set in the clearing cycle wins
        if (alarm_ev) begin
            s_next.stat[1][rta_pkg::S1_ALARM_FLAG] = 1'b1;
        end
        if (timer_ev) begin
            s_next.stat[1][rta_pkg::S1_TIMER_FLAG] = 1'b1;
        end
        if (pulse_ev) begin
            s_next.stat[1][rta_pkg::S1_PULSE_FLAG] = 1'b1;
        end

        // open drain interrupt, pulled low while an unmasked alarm flag stands, or an unmasked pulse or timer flag while power_fail_input is low
        irq_alarm = s_next.stat[1][rta_pkg::S1_ALARM_FLAG] && s_next.stat[1][rta_pkg::S1_ALARM_MASK];
        irq_other = ((s_next.stat[1][rta_pkg::S1_PULSE_FLAG] && s_next.stat[1][rta_pkg::S1_PULSE_MASK])
                  || (s_next.stat[1][rta_pkg::S1_TIMER_FLAG] && s_next.stat[1][rta_pkg::S1_TIMER_MASK]))
                  && !power_fail_input;
        s_next.irq_oe_n = !(irq_alarm || irq_other);
        s_next.irq_out = 1'b0;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '0;
            s_reg.ad_oe_n <= 1'b1;
            s_reg.irq_oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign ad_out = s_reg.ad_out;
    assign ad_oe_n = s_reg.ad_oe_n;
    assign irq_out = s_reg.irq_out;
    assign irq_oe_n = s_reg.irq_oe_n;
endmodule // rta_core
`default_nettype wire

// ==== verif/rta_core_checker.sv ====
// pin assertions for the clock core
// assumes it is bound to rta_core by the bench
`timescale 1ns/1ps
`default_nettype none
module rta_core_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic osc_pulse,
    input wire logic power_fail_input,
    input wire logic bus_cs_n,
    input wire logic bus_rd_n,
    input wire logic bus_wr_n,
    input wire logic bus_data_sel,
    input wire logic [7:0] ad_in,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe_n,
    input wire logic irq_out,
    input wire logic irq_oe_n
);
    logic [7:0] latch_reg;
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence rd_start;
        !bus_cs_n && $fell(bus_rd_n) && bus_wr_n;
    endsequence
    sequence quiet_irq;
        (bus_wr_n && $stable(power_fail_input) && !irq_oe_n)[*3];
    endsequence
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            latch_reg <= 8'h00;
        end else if (!bus_cs_n && !bus_wr_n && !bus_data_sel) begin
            latch_reg <= ad_in;
        end
    end
    irq_data_low_a: assert property (irq_out == 1'b0) else $error("irq data high");
    reset_idle_a: assert property (disable iff (1'b0) sys_rst |-> ad_oe_n && irq_oe_n)
        else $error("pins active in reset");
    rd_answer_a: assert property (rd_start |=> !ad_oe_n) else $error("read not answered");
    rd_release_a: assert property ($rose(bus_rd_n) |=> ad_oe_n) else $error("bus held");
    rd_quiet_a: assert property (bus_rd_n && $past(bus_rd_n) |-> ad_oe_n) else $error("bus driven");
    drive_select_a: assert property (!ad_oe_n |-> $past(bus_cs_n) == 1'b0)
        else $error("driven unselected");
    latch_read_a: assert property (rd_start ##0 !bus_data_sel |=> ad_out == latch_reg)
        else $error("latch read wrong");
    unmapped_zero_a: assert property (rd_start ##0 (bus_data_sel && latch_reg inside {[8'h50:8'hEF]})
        |=> ad_out == 8'h00) else $error("unmapped not zero");
    irq_hold_a: assert property (quiet_irq |=> !irq_oe_n) else $error("irq dropped");
endmodule // rta_core_checker
`default_nettype wire

// ==== verif/rta_host.sv ====
// host model on the multiplexed byte bus
// assumes the bench calls its tasks; irq line has a pullup
`timescale 1ns/1ps
`default_nettype none
module rta_host (
    input wire logic clk,
    input wire logic irq_n,
    output logic bus_cs_n,
    output logic bus_rd_n,
    output logic bus_wr_n,
    output logic bus_data_sel,
    output logic [7:0] ad_in
);
    initial begin
        bus_cs_n = 1'b1;
        bus_rd_n = 1'b1;
        bus_wr_n = 1'b1;
        bus_data_sel = 1'b0;
        ad_in = 8'h00;
    end
    task automatic acc(input logic rd, input logic ds, input logic [7:0] d);
        @(posedge clk) #2;
        bus_cs_n = 1'b0;
        bus_rd_n = !rd;
        bus_wr_n = rd;
        bus_data_sel = ds;
        ad_in = rd ? ~ad_in : d;
        repeat (rd ? 2 : 1) @(posedge clk);
        #2;
        bus_cs_n = 1'b1;
        bus_rd_n = 1'b1;
        bus_wr_n = 1'b1;
        ad_in = ~ad_in;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b0, 1'b0, a);
        acc(1'b0, 1'b1, d);
    endtask
    // status1 write after the settle time
    task automatic clr(input logic [7:0] d);
        repeat (2400) @(posedge clk);
        wr(8'h01, d);
    endtask
    task automatic wait_low(input int n, output int t);
        t = 0;
        while (irq_n !== 1'b0 && t < n) begin
            @(posedge clk);
            #1;
            t++;
        end
    endtask
endmodule // rta_host
`default_nettype wire

// ==== verif/rta_core_tb.sv ====
// bench for the clock core: host model, queued read checks, verdict
// assumes rta_pkg, rta_core, rta_host and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module rta_core_tb;
    logic clk, sys_rst, osc_pulse, power_fail_input, irq_n, oe_q;
    logic bus_cs_n, bus_rd_n, bus_wr_n, bus_data_sel, ad_oe_n, irq_out, irq_oe_n;
    logic [7:0] ad_in, ad_out, v;
    logic [7:0] exp_q[$];
    logic [7:0] trims[2] = '{8'h00, 8'h64};
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 78;
    int t0, dt, e;
    realtime tf;
    assign irq_n = irq_oe_n ? 1'b1 : irq_out;
    rta_core #(.TRIM_PERIOD(1024)) dut_u (.clk(clk), .sys_rst(sys_rst), .osc_pulse(osc_pulse),
        .power_fail_input(power_fail_input), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
        .bus_data_sel(bus_data_sel), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .irq_out(irq_out),
        .irq_oe_n(irq_oe_n));
    rta_host host_u (.clk(clk), .irq_n(irq_n), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
        .bus_data_sel(bus_data_sel), .ad_in(ad_in));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) #2 osc_pulse = ~osc_pulse;
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (!ok) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        host_u.acc(1'b0, 1'b0, a);
        exp_q.push_back(x);
        host_u.acc(1'b1, 1'b1, 8'h00);
    endtask
    always @(negedge clk) begin
        if (!ad_oe_n && oe_q) begin
            if (exp_q.size() == 0) begin
                chk(1'b0, "unexpected read");
            end else begin
                chk(ad_out === exp_q.pop_front(), "read data");
            end
        end
        oe_q = ad_oe_n;
    end
    task automatic final_report();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial begin
        sys_rst = 1'b1;
        osc_pulse = 1'b0;
        power_fail_input = 1'b0;
        oe_q = 1'b1;
        repeat (3) @(posedge clk);
        #2 sys_rst = 1'b0;
        rd(8'h00, 8'h00);
        rd(8'h10, 8'h00);
        rd(8'h60, 8'h00);
        exp_q.push_back(8'h60);
        host_u.acc(1'b1, 1'b0, 8'h00);
        v = 8'($random(seed));
        host_u.wr(8'h10, v);
        rd(8'h10, v);
        host_u.wr(8'h00, 8'h20);
        host_u.wr(8'h10, ~v);
        rd(8'h10, v);
        host_u.wr(8'h22, 8'h45);
        host_u.wr(8'hF1, 8'h00);
        rd(8'hF1, 8'h00);
        rd(8'h22, 8'h00);
        host_u.wr(8'h00, 8'h00);
        host_u.wr(8'h22, 8'h45);
        host_u.wr(8'hF1, 8'h00);
        rd(8'hF1, 8'h00);
        rd(8'h22, 8'h45);
        host_u.wr(8'h01, 8'h01);
        host_u.wr(8'h02, 8'h03);
        host_u.wr(8'h00, 8'h02);
        host_u.wait_low(2000, t0);
        chk(t0 === 2000, "pulse with two selects");
        foreach (trims[i]) begin
            host_u.wr(8'h10, trims[i]);
            host_u.wr(8'h02, 8'h02);
            host_u.wait_low(9000, t0);
            tf = $realtime;
            rd(8'h01, 8'h11);
            host_u.clr(8'h01);
            host_u.wait_low(9000, t0);
            dt = int'(($realtime - tf) / 25.0);
            e = 6554 * 1024 / (1024 - int'(trims[i]));
            chk(dt > e - 260 && dt < e + 260, "pulse interval");
            host_u.clr(8'h01);
        end
        host_u.wr(8'h02, 8'h01);
        host_u.wr(8'h01, 8'h03);
        @(posedge clk) #2 power_fail_input = 1'b1;
        host_u.wait_low(2000, t0);
        chk(t0 === 2000, "pulse in standby");
        @(posedge clk) #2 power_fail_input = 1'b0;
        host_u.wait_low(1500, t0);
        chk(t0 < 1500, "pulse after standby");
        for (int a = 8'h30; a < 8'h35; a++) host_u.wr(8'(a), 8'hFF);
        host_u.wr(8'h00, 8'h04);
        host_u.clr(8'h02);
        host_u.wait_low(1500, t0);
        chk(t0 < 1500, "alarm irq");
        rd(8'h01, 8'h22);
        host_u.clr(8'h02);
        @(posedge clk) #2 power_fail_input = 1'b1;
        host_u.wait_low(1500, t0);
        chk(t0 < 1500, "alarm in standby");
        @(posedge clk) #2 power_fail_input = 1'b0;
        host_u.clr(8'h00);
        host_u.wait_low(2000, t0);
        chk(t0 === 2000, "masked alarm");
        rd(8'h01, 8'h20);
        host_u.wr(8'h00, 8'h00);
        host_u.wr(8'h01, 8'h02);
        host_u.wait_low(2000, t0);
        chk(t0 === 2000, "disabled alarm");
        host_u.wr(8'h40, 8'h99);
        host_u.wr(8'h41, 8'h59);
        host_u.wr(8'h42, 8'h59);
        host_u.wr(8'h43, 8'h23);
        host_u.wr(8'hF2, 8'h00);
        host_u.wr(8'h01, 8'h04);
        host_u.wr(8'h00, 8'h08);
        host_u.wait_low(1500, t0);
        chk(t0 < 1500, "timer rollover irq");
        rd(8'h01, 8'h44);
        host_u.wr(8'h00, 8'h20);
        host_u.wr(8'h02, 8'h10);
        rd(8'h00, 8'h00);
        rd(8'h01, 8'h00);
        final_report();
    end
endmodule // rta_core_tb
bind rta_core rta_core_checker chk_u (.clk(clk), .sys_rst(sys_rst), .osc_pulse(osc_pulse),
    .power_fail_input(power_fail_input), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
    .bus_data_sel(bus_data_sel), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .irq_out(irq_out),
    .irq_oe_n(irq_oe_n));
`default_nettype wire
